// ---- core/uim_pkg.sv ----
// Constants and types for the interrupt mask, priority and status block
// What this block does
// (RQ1) FIFO mode with receive enable: receive interrupt follows FIFO level against trigger.
// (RQ2) Data ready status bit sets on character entry, clears when FIFO empties.
// (RQ3) Host polls with FIFOs on and low four mask bits cleared.
// (RQ4) Line status shows overrun, head errors, holding empty, all empty, any error.
// (RQ5) Mask bit 0 raises receive interrupt on data or trigger level; resets 0.
// (RQ6) Mask bit 1 raises transmit ready on emptying, below trigger, or when enabled.
// (RQ7) Mask bit 2: overrun at once; other errors at head, or on entry.
// (RQ8) Mask bit 3 enables modem status interrupt from modem bits 0 to 3.
// (RQ9) Mask bits 4 and 5 writable only with enhanced functions on; reset 0.
// (RQ10) Mask bits 6 and 7 flag rising RTS/CTS under automatic flow control.
// (RQ11) Source register reports highest pending source; serviced before next one.
// (RQ12) Receive timeout fires after four character times plus twelve bit times.
// (RQ13) Transmit ready from trigger or empty; cleared by source read or write.
// (RQ14) Line status interrupt from status bits 1 to 4; cleared by status read.
// (RQ15) Modem and handshake pin interrupts cleared by modem status read.
// (RQ16) Receive interrupt clears below trigger; timeout clears on holding read.
// (RQ17) Xon, Xoff, special detect interrupt; clears on source read, special detect also on next character.
// (RQ18) Wake-up interrupt on leaving sleep, cleared by source read, code 000001.
// (RQ19) Codes: line status 000110, timeout 001100, data 000100, transmit 000010.
// (RQ20) Codes: modem 000000, flow character 010000, handshake pin 100000.
// (RQ21) Source bit 0 low while a source other than wake-up pends, high otherwise; bits 3 to 1 encode.
// (RQ22) Source bit 4 only with enhanced functions: flow character matched.
// (RQ23) Source bit 5 only with enhanced functions: CTS or RTS rose.
// (RQ24) Source bits 7 and 6 read 1 with FIFOs on, 0 otherwise.
// (RQ25) Interrupt output active while any enabled source pending.
package uim_pkg;

   // Register offsets on A2..A0
   localparam logic [2:0] UIM_OFS_HOLDING   = 3'h0;
   localparam logic [2:0] UIM_OFS_MASK      = 3'h1;
   localparam logic [2:0] UIM_OFS_SOURCE    = 3'h2;
   localparam logic [2:0] UIM_OFS_LINE_STAT = 3'h5;
   localparam logic [2:0] UIM_OFS_MODEM_ST  = 3'h6;

   // Reset values
   localparam logic [7:0] UIM_MASK_RESET    = 8'h00;
   localparam logic [7:0] UIM_RDATA_RESET   = 8'h00;

   // Mask register fields
   localparam int UIM_MB_RX     = 0;
   localparam int UIM_MB_TX     = 1;
   localparam int UIM_MB_LINE   = 2;
   localparam int UIM_MB_MODEM  = 3;
   localparam int UIM_MB_SLEEP  = 4;
   localparam int UIM_MB_XOFF   = 5;
   localparam int UIM_MB_RTS    = 6;
   localparam int UIM_MB_CTS    = 7;
   localparam logic [7:0] UIM_MASK_ENH_BITS = 8'hf0;

   // Source codes, bits 5..0
   localparam logic [5:0] UIM_CODE_LINE    = 6'h06;
   localparam logic [5:0] UIM_CODE_TIMEOUT = 6'h0c;
   localparam logic [5:0] UIM_CODE_RXDATA  = 6'h04;
   localparam logic [5:0] UIM_CODE_TX_READY_EVENT   = 6'h02;
   localparam logic [5:0] UIM_CODE_MODEM   = 6'h00;
   localparam logic [5:0] UIM_CODE_FLOWCH  = 6'h10;
   localparam logic [5:0] UIM_CODE_PIN     = 6'h20;
   localparam logic [5:0] UIM_CODE_NONE    = 6'h01;

   // Timeout span: characters and extra bit times
   localparam int UIM_TO_CHARS     = 4;
   localparam int UIM_TO_EXTRA     = 12;
   localparam int UIM_TO_CNT_W     = 7;
   localparam int UIM_LVL_W        = 5;

   // Reported source, priority order
   typedef enum logic [2:0] {
      UIM_SRC_NONE    = 3'd0,
      UIM_SRC_LINE    = 3'd1,
      UIM_SRC_TIMEOUT = 3'd3,
      UIM_SRC_RXDATA  = 3'd2,
      UIM_SRC_TX_READY_EVENT   = 3'd6,
      UIM_SRC_MODEM   = 3'd7,
      UIM_SRC_FLOWCH  = 3'd5,
      UIM_SRC_PIN     = 3'd4
   } uim_src_type;

endpackage

// ---- core/uim_rx_timeout.sv ----
// Receive timeout timer counting bit times while data waits in the FIFO
`timescale 1ns/10ps
module uim_rx_timeout
   import uim_pkg::*;
(
   // Clock and reset
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_rst,
   // Control
   input  wire logic                    i_run,
   input  wire logic                    i_restart,
   input  wire logic                    i_bit_tick,
   input  wire logic [3:0]              i_char_bits,
   // Expiry
   output logic                         o_expired
);

   logic [UIM_TO_CNT_W-1:0] count_q;
   logic [UIM_TO_CNT_W-1:0] count_d;
   logic                    expired_q;
   logic                    expired_d;
   wire  [UIM_TO_CNT_W-1:0] span;
   wire                     at_span;

   // Char time taken in bit times from the current frame format
   assign span    = UIM_TO_CNT_W'(UIM_TO_CHARS) * UIM_TO_CNT_W'(i_char_bits)
                    + UIM_TO_CNT_W'(UIM_TO_EXTRA);  // see (RQ12)
   assign at_span = (count_q >= span);

   always_comb begin
      count_d   = count_q;
      expired_d = expired_q;
      if (i_restart || !i_run) begin
         count_d   = '0;
         expired_d = 1'b0;
      end else if (i_bit_tick && !at_span) begin
         count_d = count_q + 1'b1;
      end else if (at_span) begin
         expired_d = 1'b1;  // see (RQ12)
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         count_q   <= '0;
         expired_q <= 1'b0;
      end else begin
         count_q   <= count_d;
         expired_q <= expired_d;
      end
   end

   assign o_expired = expired_q;

endmodule

// ---- core/uim_ctrl.sv ----
// Interrupt mask, priority encoder, source and line status registers
`timescale 1ns/10ps
module uim_ctrl
   import uim_pkg::*;
(
   // Clock and reset
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   // Host register port
   input  wire logic [2:0]            i_addr,
   input  wire logic                  i_rd_stb,
   input  wire logic                  i_wr_stb,
   input  wire logic [7:0]            i_wdata,
   input  wire logic                  i_divisor_sel,
   output logic [7:0]                 o_rdata,
   // Configuration from neighbouring registers
   input  wire logic                  i_fifo_en,
   input  wire logic                  i_enh_en,
   input  wire logic                  i_auto_rts_en,
   input  wire logic                  i_auto_cts_en,
   input  wire logic                  i_line_on_entry,
   input  wire logic                  i_wake_int_en,
   // Receive side
   input  wire logic [UIM_LVL_W-1:0]  i_rx_level,
   input  wire logic [UIM_LVL_W-1:0]  i_rx_trig,
   input  wire logic                  i_rx_push,
   input  wire logic [2:0]            i_rx_push_err,
   input  wire logic [2:0]            i_head_err,
   input  wire logic                  i_overrun,
   input  wire logic                  i_fifo_any_err,
   input  wire logic                  i_bit_tick,
   input  wire logic [3:0]            i_char_bits,
   // Transmit side
   input  wire logic [UIM_LVL_W-1:0]  i_tx_level,
   input  wire logic [UIM_LVL_W-1:0]  i_tx_trig,
   input  wire logic                  i_thr_empty,
   input  wire logic                  i_tx_all_empty,
   // Modem, flow control and sleep events
   input  wire logic [3:0]            i_modem_delta,
   input  wire logic                  i_rts_out,
   input  wire logic                  i_cts_in,
   input  wire logic                  i_xon_det,
   input  wire logic                  i_xoff_det,
   input  wire logic                  i_special_det,
   input  wire logic                  i_wake_evt,
   // Outputs
   output logic                       o_irq,
   output logic                       o_sleep_en,
   output logic [7:0]                 o_line_status
);

   // Register state
   logic [7:0]  mask_q;
   logic [7:0]  mask_d;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic        overrun_q;
   logic        line_int_q;
   logic        tx_int_q;
   logic        modem_int_q;
   logic        pin_int_q;
   logic        xonoff_int_q;
   logic        special_int_q;
   logic        wake_int_q;
   logic        thr_empty_q;
   logic        tx_below_q;
   logic        tx_empty_q;
   logic        rts_q;
   logic        cts_q;
   logic [3:0]  modem_delta_q;
   logic        head_err_seen_q;

   // Access decode
   wire rd_holding = i_rd_stb && (i_addr == UIM_OFS_HOLDING) && !i_divisor_sel;
   wire wr_holding = i_wr_stb && (i_addr == UIM_OFS_HOLDING) && !i_divisor_sel;
   wire wr_mask    = i_wr_stb && (i_addr == UIM_OFS_MASK) && !i_divisor_sel;
   wire rd_mask    = i_rd_stb && (i_addr == UIM_OFS_MASK) && !i_divisor_sel;
   wire rd_source  = i_rd_stb && (i_addr == UIM_OFS_SOURCE);
   wire rd_line    = i_rd_stb && (i_addr == UIM_OFS_LINE_STAT);
   wire rd_modem   = i_rd_stb && (i_addr == UIM_OFS_MODEM_ST);

   // Receive data condition: holding full, or trigger reached in FIFO mode
   wire rx_has_data = (i_rx_level != '0);
   wire rx_at_trig  = (i_rx_level >= i_rx_trig);
   wire rx_cond     = i_fifo_en ? rx_at_trig : rx_has_data;  // see (RQ1) (RQ5) (RQ16)

   // Receive timeout only matters with FIFOs on and data waiting
   wire timeout_hit;
   uim_rx_timeout u_timeout (
      .i_clk_sys   (i_clk_sys),
      .i_rst       (i_rst),
      .i_run       (i_fifo_en && rx_has_data),
      .i_restart   (i_rx_push || rd_holding),  // see (RQ16)
      .i_bit_tick  (i_bit_tick),
      .i_char_bits (i_char_bits),
      .o_expired   (timeout_hit)
   );

   // Transmit ready events
   wire tx_below     = (i_tx_level < i_tx_trig);
   wire tx_empty     = (i_tx_level == '0);
   wire tx_fifo_evt  = (tx_below && !tx_below_q) || (tx_empty && !tx_empty_q);
   wire tx_plain_evt = i_thr_empty && !thr_empty_q;
   wire tx_en_evt    = wr_mask && i_wdata[UIM_MB_TX] && !mask_q[UIM_MB_TX] && i_thr_empty;
   wire tx_set       = (i_fifo_en ? tx_fifo_evt : tx_plain_evt) || tx_en_evt;  // see (RQ6) (RQ13)

   // Line status events: overrun at once, others at head or on entry
   wire head_err_new = (i_head_err != 3'b000) && !head_err_seen_q;
   wire entry_err    = i_rx_push && (i_rx_push_err != 3'b000);
   wire line_set     = i_overrun
                       || (i_line_on_entry ? entry_err : head_err_new);  // see (RQ7) (RQ14)

   // Modem and handshake pin events
   wire modem_set = |(i_modem_delta & ~modem_delta_q);  // see (RQ8)
   wire rts_rise  = i_rts_out && !rts_q && i_auto_rts_en && mask_q[UIM_MB_RTS];
   wire cts_rise  = i_cts_in && !cts_q && i_auto_cts_en && mask_q[UIM_MB_CTS];
   wire pin_set   = i_enh_en && (rts_rise || cts_rise);  // see (RQ10) (RQ23)

   // Flow character events, only with enhanced functions
   wire xonoff_set  = i_enh_en && mask_q[UIM_MB_XOFF] && (i_xon_det || i_xoff_det);
   wire special_set = i_enh_en && mask_q[UIM_MB_XOFF] && i_special_det;

   // Enabled pending sources
   wire p_line    = line_int_q && mask_q[UIM_MB_LINE];
   wire p_timeout = timeout_hit && mask_q[UIM_MB_RX] && i_fifo_en;
   wire p_rxdata  = rx_cond && mask_q[UIM_MB_RX];
   wire p_tx_ready_event   = tx_int_q && mask_q[UIM_MB_TX];
   wire p_modem   = modem_int_q && mask_q[UIM_MB_MODEM];
   wire p_flowch  = (xonoff_int_q || special_int_q) && i_enh_en;  // see (RQ22)
   wire p_pin     = pin_int_q && i_enh_en;
   wire p_wake    = wake_int_q;

   // Highest priority wins; lower ones stay pending in their own flags
   uim_src_type src;
   always_comb begin
      if (p_line) begin
         src = UIM_SRC_LINE;
      end else if (p_timeout) begin
         src = UIM_SRC_TIMEOUT;
      end else if (p_rxdata) begin
         src = UIM_SRC_RXDATA;
      end else if (p_tx_ready_event) begin
         src = UIM_SRC_TX_READY_EVENT;
      end else if (p_modem) begin
         src = UIM_SRC_MODEM;
      end else if (p_flowch) begin
         src = UIM_SRC_FLOWCH;
      end else if (p_pin) begin
         src = UIM_SRC_PIN;
      end else begin
         src = UIM_SRC_NONE;
      end
   end  // see (RQ11)

   // Source code lookup
   logic [5:0] code;
   always_comb begin
      case (src)
         UIM_SRC_LINE:    code = UIM_CODE_LINE;     // see (RQ19)
         UIM_SRC_TIMEOUT: code = UIM_CODE_TIMEOUT;  // see (RQ19)
         UIM_SRC_RXDATA:  code = UIM_CODE_RXDATA;   // see (RQ19)
         UIM_SRC_TX_READY_EVENT:   code = UIM_CODE_TX_READY_EVENT;    // see (RQ19)
         UIM_SRC_MODEM:   code = UIM_CODE_MODEM;    // see (RQ20)
         UIM_SRC_FLOWCH:  code = UIM_CODE_FLOWCH;   // see (RQ20)
         UIM_SRC_PIN:     code = UIM_CODE_PIN;      // see (RQ20)
         default:         code = UIM_CODE_NONE;     // see (RQ18) (RQ21)
      endcase
   end

   // Bits 7..6 mirror FIFO enable
   wire [7:0] source_val = {{2{i_fifo_en}}, code};  // see (RQ24)

   // A source read services only the source it reports, so queued ones survive
   wire svc_tx   = rd_source && (src == UIM_SRC_TX_READY_EVENT);
   wire svc_flow = rd_source && (src == UIM_SRC_FLOWCH);
   wire svc_wake = rd_source && (src == UIM_SRC_NONE);

   // Line status value
   assign o_line_status = {i_fifo_any_err,   // see (RQ4)
                           i_tx_all_empty,
                           i_thr_empty,
                           i_head_err,
                           overrun_q,
                           rx_has_data};      // see (RQ2)

   // Mask write: upper half only with enhanced functions on
   always_comb begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = i_enh_en ? i_wdata
                           : ((mask_q & UIM_MASK_ENH_BITS) | (i_wdata & ~UIM_MASK_ENH_BITS));
      end  // see (RQ9)
   end

   // Read mux, registered
   always_comb begin
      rdata_d = rdata_q;
      if (rd_mask) begin
         rdata_d = mask_q;
      end else if (rd_source) begin
         rdata_d = source_val;
      end else if (rd_line) begin
         rdata_d = o_line_status;
      end else if (i_rd_stb) begin
         rdata_d = 8'h00;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         mask_q  <= UIM_MASK_RESET;  // see (RQ5) (RQ8) (RQ9)
         rdata_q <= UIM_RDATA_RESET;
      end else begin
         mask_q  <= mask_d;
         rdata_q <= rdata_d;
      end
   end

   // Edge history
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         thr_empty_q     <= 1'b1;
         tx_below_q      <= 1'b1;
         tx_empty_q      <= 1'b1;
         rts_q           <= 1'b0;
         cts_q           <= 1'b0;
         modem_delta_q   <= 4'h0;
         head_err_seen_q <= 1'b0;
      end else begin
         thr_empty_q     <= i_thr_empty;
         tx_below_q      <= tx_below;
         tx_empty_q      <= tx_empty;
         rts_q           <= i_rts_out;
         cts_q           <= i_cts_in;
         modem_delta_q   <= i_modem_delta;
         head_err_seen_q <= (i_head_err != 3'b000) && !rd_holding;
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         overrun_q <= 1'b0;
      end else begin
         overrun_q <= i_overrun || (overrun_q && !rd_line);  // see (RQ4)
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         line_int_q <= 1'b0;
      end else begin
         line_int_q <= line_set || (line_int_q && !rd_line);  // see (RQ14)
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         tx_int_q <= 1'b0;
      end else begin
         tx_int_q <= tx_set || (tx_int_q && !svc_tx && !wr_holding);  // see (RQ13)
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         modem_int_q <= 1'b0;
         pin_int_q   <= 1'b0;
      end else begin
         modem_int_q <= modem_set || (modem_int_q && !rd_modem);  // see (RQ15)
         pin_int_q   <= pin_set || (pin_int_q && !rd_modem);      // see (RQ15)
      end
   end

   // Special character also drops when the next character lands
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         xonoff_int_q  <= 1'b0;
         special_int_q <= 1'b0;
      end else begin
         xonoff_int_q  <= xonoff_set || (xonoff_int_q && !svc_flow);  // see (RQ17)
         special_int_q <= special_set
                          || (special_int_q && !svc_flow && !i_rx_push);  // see (RQ17)
      end
   end

   // Wake-up reads as the idle code, so any source read with nothing else clears it
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wake_int_q <= 1'b0;
      end else begin
         wake_int_q <= (i_wake_evt && i_wake_int_en && i_enh_en)
                       || (wake_int_q && !svc_wake);  // see (RQ18)
      end
   end

   // Polled mode needs no special logic: with mask bits 3..0 clear only flow character, handshake pin and wake-up can pend
   assign o_irq      = (src != UIM_SRC_NONE) || p_wake;  // see (RQ25) (RQ3)
   assign o_sleep_en = mask_q[UIM_MB_SLEEP] && i_enh_en;
   assign o_rdata    = rdata_q;

endmodule

// ---- testbench/uim_ctrl_chk.sv ----
// Port assertions for the mask, priority and status block
`timescale 1ns/10ps
module uim_ctrl_chk
   import uim_pkg::*;
(
   // Clock and reset
   input  wire logic                 i_clk_sys,
   input  wire logic                 i_rst,
   // Host port
   input  wire logic [2:0]           i_addr,
   input  wire logic                 i_rd_stb,
   input  wire logic                 i_wr_stb,
   input  wire logic [7:0]           i_wdata,
   input  wire logic                 i_divisor_sel,
   input  wire logic [7:0]           o_rdata,
   // Status sources
   input  wire logic                 i_fifo_en,
   input  wire logic [UIM_LVL_W-1:0] i_rx_level,
   input  wire logic [UIM_LVL_W-1:0] i_rx_trig,
   input  wire logic [2:0]           i_head_err,
   input  wire logic                 i_overrun,
   input  wire logic                 i_fifo_any_err,
   input  wire logic                 i_thr_empty,
   input  wire logic                 i_tx_all_empty,
   input  wire logic                 i_wake_evt,
   // Watched outputs
   input  wire logic                 o_irq,
   input  wire logic [7:0]           o_line_status
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   // Shadow of low mask bits only; upper bits need the enhanced gate
   wire        mask_wr = i_wr_stb && !i_rd_stb && i_addr == UIM_OFS_MASK && !i_divisor_sel;
   wire        src_rd  = i_rd_stb && i_addr == UIM_OFS_SOURCE;
   logic [3:0] msk_q;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         msk_q <= 4'h0;
      end else if (mask_wr) begin
         msk_q <= i_wdata[3:0];
      end
   end

   a_data_ready: assert property (o_line_status[0] == (i_rx_level != '0))
      else $error("data ready bit does not follow receive level");
   a_status_map: assert property (o_line_status[7:2] ==
      {i_fifo_any_err, i_tx_all_empty, i_thr_empty, i_head_err})
      else $error("line status fields misplaced");
   a_overrun_bit: assert property (i_overrun |=> o_line_status[1])
      else $error("overrun not shown in line status");
   a_status_read: assert property (i_rd_stb && i_addr == UIM_OFS_LINE_STAT
      |=> o_rdata == $past(o_line_status))
      else $error("line status read returned wrong value");
   a_fifo_bits: assert property (src_rd |=> o_rdata[7:6] == {2{$past(i_fifo_en)}})
      else $error("source top bits do not match fifo enable");
   a_idle_code: assert property (src_rd && !o_irq |=> o_rdata[5:0] == UIM_CODE_NONE)
      else $error("idle source code wrong");
   a_line_irq: assert property (i_overrun && msk_q[2] |=> o_irq)
      else $error("overrun did not interrupt");
   a_rx_irq: assert property (i_fifo_en && msk_q[0] && i_rx_trig != '0
      && i_rx_level >= i_rx_trig |-> o_irq)
      else $error("receive trigger did not interrupt");
   a_tx_enable: assert property (mask_wr && i_wdata[1] && !msk_q[1] && i_thr_empty
      |-> ##[1:2] o_irq)
      else $error("transmit ready missing on enable");

   c_src_pending: cover property (src_rd && o_irq);
   c_overrun: cover property (i_overrun && msk_q[2]);
   c_wake: cover property (i_wake_evt ##2 o_irq);
endmodule

// ---- testbench/uim_host_model.sv ----
// Host processor model on the register port, one byte per access
`timescale 1ns/10ps
module uim_host_model
   import uim_pkg::*;
(
   // Clock
   input  wire logic       i_clk_sys,
   // Register port
   input  wire logic [7:0] i_rdata,
   output logic [2:0]      o_addr,
   output logic            o_rd_stb,
   output logic            o_wr_stb,
   output logic [7:0]      o_wdata,
   output logic            o_divisor_sel
);
   initial begin
      {o_addr, o_rd_stb, o_wr_stb, o_wdata, o_divisor_sel} = '0;
   end

   // Released lines show the inverse so stale values never match
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr   <= a;
      o_rd_stb <= 1'b1;
      @(posedge i_clk_sys);
      o_rd_stb <= 1'b0;
      o_addr   <= ~a;
      @(posedge i_clk_sys);
      #1 d = i_rdata;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      o_addr   <= a;
      o_wdata  <= d;
      o_wr_stb <= 1'b1;
      @(posedge i_clk_sys);
      o_wr_stb <= 1'b0;
      o_addr   <= ~a;
      o_wdata  <= ~d;
   endtask
endmodule

// ---- testbench/uim_ctrl_tb.sv ----
// Self-checking bench for the interrupt mask, priority and status block
`timescale 1ns/10ps
module uim_ctrl_tb
   import uim_pkg::*;
;
   logic                 i_clk_sys, i_rst, i_rd_stb, i_wr_stb, i_divisor_sel;
   logic [2:0]           i_addr, i_rx_push_err, i_head_err;
   logic [7:0]           i_wdata, o_rdata, o_line_status;
   logic                 o_irq, o_sleep_en, i_fifo_en, i_enh_en, i_auto_rts_en, i_auto_cts_en;
   logic                 i_line_on_entry, i_wake_int_en, i_rx_push, i_overrun, i_fifo_any_err;
   logic                 i_bit_tick, i_thr_empty, i_tx_all_empty, i_rts_out, i_cts_in;
   logic                 i_xon_det, i_xoff_det, i_special_det, i_wake_evt;
   logic [UIM_LVL_W-1:0] i_rx_level, i_rx_trig, i_tx_level, i_tx_trig;
   logic [3:0]           i_char_bits, i_modem_delta;
   logic [7:0]           rd_q;
   int                   err_total, total_checks;

   uim_host_model u_host (.i_clk_sys, .i_rdata(o_rdata), .o_addr(i_addr), .o_rd_stb(i_rd_stb),
      .o_wr_stb(i_wr_stb), .o_wdata(i_wdata), .o_divisor_sel(i_divisor_sel));
   uim_ctrl u_dut (.i_clk_sys, .i_rst, .i_addr, .i_rd_stb, .i_wr_stb, .i_wdata, .i_divisor_sel,
      .o_rdata, .i_fifo_en, .i_enh_en, .i_auto_rts_en, .i_auto_cts_en, .i_line_on_entry,
      .i_wake_int_en, .i_rx_level, .i_rx_trig, .i_rx_push, .i_rx_push_err, .i_head_err,
      .i_overrun, .i_fifo_any_err, .i_bit_tick, .i_char_bits, .i_tx_level, .i_tx_trig,
      .i_thr_empty, .i_tx_all_empty, .i_modem_delta, .i_rts_out, .i_cts_in, .i_xon_det,
      .i_xoff_det, .i_special_det, .i_wake_evt, .o_irq, .o_sleep_en, .o_line_status);

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic er(input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] d;
      u_host.rd(a, d);
      chk(d, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic irq_is(input logic v);
      #1 chk({7'h00, o_irq}, {7'h00, v});
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   // Hang guard, far above the few hundred cycles the tests need
   initial begin
      tick(5000);
      err_total++;
      final_report();
   end

   initial begin
      {i_fifo_en, i_enh_en, i_auto_rts_en, i_auto_cts_en, i_line_on_entry, i_wake_int_en} = '0;
      {i_rx_push, i_overrun, i_fifo_any_err, i_bit_tick, i_rts_out, i_cts_in} = '0;
      {i_xon_det, i_xoff_det, i_special_det, i_wake_evt, i_modem_delta} = '0;
      {i_rx_level, i_tx_level, i_tx_trig, i_rx_push_err, i_head_err} = '0;
      {err_total, total_checks} = '0;
      {i_thr_empty, i_tx_all_empty, i_rst} = 3'h7;
      i_rx_trig   = 5'h04;
      i_char_bits = 4'h8;
      tick(16);
      i_rst <= 1'b0;
      // Reset state, then polled use with the low mask bits clear
      er(UIM_OFS_MASK, 8'h00);
      er(UIM_OFS_SOURCE, 8'h01);
      er(3'h3, 8'h00);
      tick(1);
      {i_fifo_en, i_fifo_any_err, i_tx_all_empty} <= 3'h6;
      i_rx_level <= 5'h01;
      tick(1);
      #1 chk(o_line_status, 8'ha1);
      irq_is(1'b0);
      tick(1);
      {i_fifo_any_err, i_tx_all_empty} <= 2'h1;
      i_rx_level <= 5'h00;
      er(UIM_OFS_SOURCE, 8'hc1);
      // Upper mask bits only take writes with enhanced functions on
      u_host.wr(UIM_OFS_MASK, 8'hf5);
      er(UIM_OFS_MASK, 8'h05);
      i_enh_en <= 1'b1;
      u_host.wr(UIM_OFS_MASK, 8'hf5);
      er(UIM_OFS_MASK, 8'hf5);
      chk({7'h00, o_sleep_en}, 8'h01);
      u_host.wr(UIM_OFS_MASK, 8'h2d);
      // Four sources at once, served strictly by priority
      tick(1);
      {i_overrun, i_xoff_det} <= 2'h3;
      i_modem_delta <= 4'h1;
      i_rx_level    <= 5'h04;
      tick(1);
      {i_overrun, i_xoff_det} <= 2'h0;
      tick(1);
      irq_is(1'b1);
      er(UIM_OFS_SOURCE, 8'hc6);
      er(UIM_OFS_LINE_STAT, 8'h63);
      er(UIM_OFS_SOURCE, 8'hc4);
      tick(1);
      i_rx_level <= 5'h02;
      er(UIM_OFS_SOURCE, 8'hc0);
      u_host.rd(UIM_OFS_MODEM_ST, rd_q);
      er(UIM_OFS_SOURCE, 8'hd0);
      er(UIM_OFS_SOURCE, 8'hc1);
      irq_is(1'b0);
      // Special character cleared by the next received character
      tick(1);
      i_special_det <= 1'b1;
      i_rx_level    <= 5'h00;
      tick(1);
      i_special_det <= 1'b0;
      i_rx_push     <= 1'b1;
      tick(1);
      i_rx_push <= 1'b0;
      er(UIM_OFS_SOURCE, 8'hc1);
      i_xon_det <= 1'b1;
      tick(1);
      i_xon_det <= 1'b0;
      er(UIM_OFS_SOURCE, 8'hd0);
      er(UIM_OFS_SOURCE, 8'hc1);
      // Transmit ready on enable, cleared by source read or holding write
      u_host.wr(UIM_OFS_MASK, 8'h02);
      er(UIM_OFS_SOURCE, 8'hc2);
      er(UIM_OFS_SOURCE, 8'hc1);
      u_host.wr(UIM_OFS_MASK, 8'h00);
      u_host.wr(UIM_OFS_MASK, 8'h02);
      u_host.wr(UIM_OFS_HOLDING, 8'h55);
      er(UIM_OFS_SOURCE, 8'hc1);
      // Timeout span 4 * 5 + 12 = 32 bit times, data below trigger
      u_host.wr(UIM_OFS_MASK, 8'h01);
      tick(1);
      i_char_bits <= 4'h5;
      i_rx_push   <= 1'b1;
      i_rx_level  <= 5'h01;
      tick(1);
      i_rx_push  <= 1'b0;
      i_bit_tick <= 1'b1;
      tick(28);
      irq_is(1'b0);
      tick(12);
      i_bit_tick <= 1'b0;
      er(UIM_OFS_SOURCE, 8'hcc);
      u_host.rd(UIM_OFS_HOLDING, rd_q);
      er(UIM_OFS_SOURCE, 8'hc1);
      // Handshake pins count only under automatic flow control
      i_rx_level    <= 5'h00;
      i_auto_cts_en <= 1'b1;
      u_host.wr(UIM_OFS_MASK, 8'h80);
      i_cts_in <= 1'b1;
      tick(2);
      er(UIM_OFS_SOURCE, 8'he0);
      u_host.rd(UIM_OFS_MODEM_ST, rd_q);
      er(UIM_OFS_SOURCE, 8'hc1);
      u_host.wr(UIM_OFS_MASK, 8'h40);
      i_rts_out <= 1'b1;
      tick(2);
      er(UIM_OFS_SOURCE, 8'hc1);
      // Head error interrupt, cleared by a line status read
      u_host.wr(UIM_OFS_MASK, 8'h04);
      i_head_err <= 3'h4;
      tick(2);
      er(UIM_OFS_SOURCE, 8'hc6);
      er(UIM_OFS_LINE_STAT, 8'h70);
      i_head_err <= 3'h0;
      er(UIM_OFS_SOURCE, 8'hc1);
      i_line_on_entry <= 1'b1;
      {i_rx_push, i_rx_push_err} <= 4'h9;
      tick(1);
      i_rx_push <= 1'b0;
      er(UIM_OFS_SOURCE, 8'hc6);
      // Wake-up drives the output yet reads the idle code
      u_host.wr(UIM_OFS_MASK, 8'h00);
      {i_wake_int_en, i_wake_evt} <= 2'h3;
      tick(1);
      i_wake_evt <= 1'b0;
      tick(1);
      irq_is(1'b1);
      er(UIM_OFS_SOURCE, 8'hc1);
      irq_is(1'b0);
      final_report();
   end
endmodule

bind uim_ctrl uim_ctrl_chk u_chk (.i_clk_sys, .i_rst, .i_addr, .i_rd_stb, .i_wr_stb, .i_wdata,
   .i_divisor_sel, .o_rdata, .i_fifo_en, .i_rx_level, .i_rx_trig, .i_head_err, .i_overrun,
   .i_fifo_any_err, .i_thr_empty, .i_tx_all_empty, .i_wake_evt, .o_irq, .o_line_status);
